// File: ptc_time_clock.v
// Time-of-day clock with direct set, signed step, permanent and temporary
// rate correction, and a frequency-corrected clock output.
// Assumes a register master on core_clk_i that uses one-cycle strobes,
// and an optional external reference pin with no timing relation to it.
`timescale 1ns/1ps
`include "ptc_consts.vh"
`default_nettype none

module ptc_time_clock (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire        ce_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wr_data_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire        ext_ref_i,
  output reg  [31:0] rd_data_o,
  output reg  [31:0] time_sec_o,
  output reg  [29:0] time_ns_o,
  output reg         temp_active_o,
  output wire        clk_out_o
);

  // Advance nanoseconds and fraction by inc; top bit is the second carry
  function [62:0] ptc_adv;
    input [29:0] ns;
    input [31:0] frac;
    input [37:0] inc;
    reg   [62:0] sum;
    begin
      sum = {1'b0, ns, frac} + {25'h0, inc};
      if (sum[62:32] >= {1'b0, `PTC_NS_PER_SEC})
      begin
        ptc_adv = {1'b1, sum[61:32] - `PTC_NS_PER_SEC, sum[31:0]};
      end
      else
      begin
        ptc_adv = {1'b0, sum[61:0]};
      end
    end
  endfunction

  // Add a signed offset to nanoseconds; returns {carry up, borrow, ns}
  function [31:0] ptc_step;
    input [29:0] ns;
    input [31:0] offs;
    reg signed [33:0] s;
    begin
      s = $signed({4'h0, ns}) + $signed({{2{offs[31]}}, offs});
      if (s < 34'sd0)
      begin
        s        = s + $signed({4'h0, `PTC_NS_PER_SEC});
        ptc_step = {2'b01, s[29:0]};
      end
      else if (s >= $signed({4'h0, `PTC_NS_PER_SEC}))
      begin
        s        = s - $signed({4'h0, `PTC_NS_PER_SEC});
        ptc_step = {2'b10, s[29:0]};
      end
      else
      begin
        ptc_step = {2'b00, s[29:0]};
      end
    end
  endfunction

  // Per-tick increment: nominal period with a signed 2^-32 ns correction
  function [35:0] ptc_inc;
    input [31:0] rate;
    begin
      if (rate[`PTC_RATE_DIR])
      begin
        ptc_inc = {`PTC_REF_PERIOD_NS, 32'h0} - {6'h0, rate[`PTC_RATE_VAL_HI:0]};
      end
      else
      begin
        ptc_inc = {`PTC_REF_PERIOD_NS, 32'h0} + {6'h0, rate[`PTC_RATE_VAL_HI:0]};
      end
    end
  endfunction

  // Control and staging registers
  reg        run;
  reg [1:0]  ref_sel;
  reg        out_en;
  reg [29:0] set_ns;
  reg [31:0] set_sec;
  reg [31:0] step_offs;
  reg [31:0] perm_rate;
  reg [31:0] temp_rate;
  reg [31:0] rate_dur;
  reg [31:0] dur_left;
  reg [7:0]  out_div;

  // Control reset image, split into its fields at reset
  localparam [6:0] ctrl_rst_val = `PTC_CTRL_RST;

  // Time state beyond the ports
  reg [31:0] time_frac;
  reg [29:0] snap_ns;
  reg [31:0] snap_frac;

  // Reference tick sources
  reg  [1:0] div_cnt;
  reg        ext_q;
  wire       ext_s;

  // Command decode
  wire wr_ctrl;
  wire load_cmd;
  wire step_cmd;
  wire wr_rate;

  // Datapath
  wire [35:0] inc_base;
  wire [37:0] inc;
  reg         tick;
  wire [62:0] adv;
  wire [29:0] adv_ns;
  wire [31:0] adv_frac;
  wire [31:0] adv_sec;
  wire [31:0] stepped;
  reg  [31:0] next_sec;
  reg  [29:0] next_ns;
  reg  [31:0] next_frac;

  // External reference pin crosses into the clock domain first
  ptc_sync2 u_ext_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .async_i    (ext_ref_i),
    .sync_o     (ext_s)
  );

  assign wr_ctrl  = wr_i && (addr_i == `PTC_ADDR_CTRL);
  assign load_cmd = wr_ctrl && wr_data_i[`PTC_CTRL_LOAD];
  assign step_cmd = wr_ctrl && wr_data_i[`PTC_CTRL_STEP];
  assign wr_rate  = wr_i && (addr_i == `PTC_ADDR_RATE);

  // Increment follows the temporary rate while it is active
  assign inc_base = ptc_inc(temp_active_o ? temp_rate : perm_rate);
  // A divided tick stands for four reference periods
  assign inc      = (ref_sel == `PTC_REF_DIV) ? {inc_base, 2'b00} : {2'b00, inc_base};

  // Tick selection between internal, divided and external references
  always @*
  begin
    if (!run)
    begin
      tick = 1'b0;
    end
    else if (ref_sel == `PTC_REF_INT)
    begin
      tick = 1'b1;
    end
    else if (ref_sel == `PTC_REF_DIV)
    begin
      tick = (div_cnt == `PTC_REF_DIV_LAST);
    end
    else if (ref_sel == `PTC_REF_EXT)
    begin
      tick = ext_s && !ext_q;
    end
    else
    begin
      tick = 1'b0;
    end
  end

  // Free-running advance, then an optional step on top of it
  assign adv      = ptc_adv(time_ns_o, time_frac, inc);
  assign adv_ns   = tick ? adv[61:32] : time_ns_o;
  assign adv_frac = tick ? adv[31:0] : time_frac;
  assign adv_sec  = (tick && adv[62]) ? time_sec_o + 32'h1 : time_sec_o;
  assign stepped  = ptc_step(adv_ns, step_offs);

  // Next time: a load wins over a step, a step rides on the tick
  always @*
  begin
    next_sec  = adv_sec;
    next_ns   = adv_ns;
    next_frac = adv_frac;
    if (load_cmd)
    begin
      next_sec  = set_sec;
      next_ns   = set_ns;
      next_frac = 32'h0;
    end
    else if (step_cmd)
    begin
      next_ns = stepped[29:0];
      if (stepped[31])
      begin
        next_sec = adv_sec + 32'h1;
      end
      else if (stepped[30])
      begin
        next_sec = adv_sec - 32'h1;
      end
    end
  end

  // Time registers; seconds wrap silently at the top of 32 bits
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      time_sec_o <= 32'h0;
      time_ns_o  <= 30'h0;
      time_frac  <= 32'h0;
    end
    else if (ce_i)
    begin
      time_sec_o <= next_sec;
      time_ns_o  <= next_ns;
      time_frac  <= next_frac;
    end
  end

  // Divided tick counter and external edge history
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt <= 2'h0;
      ext_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      div_cnt <= div_cnt + 2'h1;
      ext_q   <= ext_s;
    end
  end

  // Control, staging and divisor registers
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      run       <= ctrl_rst_val[`PTC_CTRL_RUN];
      ref_sel   <= ctrl_rst_val[`PTC_CTRL_REF_HI:`PTC_CTRL_REF_LO];
      out_en    <= ctrl_rst_val[`PTC_CTRL_OUT_EN];
      set_ns    <= 30'h0;
      set_sec   <= 32'h0;
      step_offs <= 32'h0;
      rate_dur  <= 32'h0;
      out_div   <= `PTC_COC_DIV_RST;
    end
    else if (ce_i && wr_i)
    begin
      if (addr_i == `PTC_ADDR_CTRL)
      begin
        run     <= wr_data_i[`PTC_CTRL_RUN];
        ref_sel <= wr_data_i[`PTC_CTRL_REF_HI:`PTC_CTRL_REF_LO];
        out_en  <= wr_data_i[`PTC_CTRL_OUT_EN];
      end
      else if (addr_i == `PTC_ADDR_SET_NS)
      begin
        set_ns <= wr_data_i[29:0];
      end
      else if (addr_i == `PTC_ADDR_SET_SEC)
      begin
        set_sec <= wr_data_i;
      end
      else if (addr_i == `PTC_ADDR_STEP)
      begin
        step_offs <= wr_data_i;
      end
      else if (addr_i == `PTC_ADDR_RATE_DUR)
      begin
        rate_dur <= wr_data_i;
      end
      else if (addr_i == `PTC_ADDR_COC)
      begin
        // Divisors outside 2..255 leave the old value in place
        if (wr_data_i[7:0] >= `PTC_COC_DIV_MIN && wr_data_i[31:8] == 24'h0)
        begin
          out_div <= wr_data_i[7:0];
        end
      end
    end
  end

  // Rate control; a fresh rate write wins over the countdown ending
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      perm_rate     <= 32'h0;
      temp_rate     <= 32'h0;
      dur_left      <= 32'h0;
      temp_active_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (temp_active_o && tick)
      begin
        dur_left <= dur_left - 32'h1;
        if (dur_left == 32'h1)
        begin
          temp_active_o <= 1'b0;
        end
      end
      if (wr_rate)
      begin
        if (wr_data_i[`PTC_RATE_TEMP] && rate_dur != 32'h0)
        begin
          temp_rate     <= wr_data_i;
          dur_left      <= rate_dur;
          temp_active_o <= 1'b1;
        end
        else
        begin
          perm_rate     <= wr_data_i;
          temp_active_o <= 1'b0;
        end
      end
    end
  end

  // Reading seconds freezes ns and fraction so a multi-word read is coherent
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      snap_ns   <= 30'h0;
      snap_frac <= 32'h0;
    end
    else if (ce_i && rd_i && addr_i == `PTC_ADDR_NOW_SEC)
    begin
      snap_ns   <= time_ns_o;
      snap_frac <= time_frac;
    end
  end

  // Read data stands for one cycle only; unmapped offsets read zero
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o <= 32'h0;
    end
    else if (ce_i)
    begin
      if (!rd_i)
      begin
        rd_data_o <= 32'h0;
      end
      else if (addr_i == `PTC_ADDR_CTRL)
      begin
        rd_data_o <= {25'h0, out_en, ref_sel, 3'h0, run};
      end
      else if (addr_i == `PTC_ADDR_SET_NS)
      begin
        rd_data_o <= {2'h0, set_ns};
      end
      else if (addr_i == `PTC_ADDR_SET_SEC)
      begin
        rd_data_o <= set_sec;
      end
      else if (addr_i == `PTC_ADDR_STEP)
      begin
        rd_data_o <= step_offs;
      end
      else if (addr_i == `PTC_ADDR_RATE)
      begin
        rd_data_o <= temp_active_o ? temp_rate : perm_rate;
      end
      else if (addr_i == `PTC_ADDR_RATE_DUR)
      begin
        rd_data_o <= temp_active_o ? dur_left : rate_dur;
      end
      else if (addr_i == `PTC_ADDR_COC)
      begin
        rd_data_o <= {24'h0, out_div};
      end
      else if (addr_i == `PTC_ADDR_NOW_SEC)
      begin
        rd_data_o <= time_sec_o;
      end
      else if (addr_i == `PTC_ADDR_NOW_NS)
      begin
        rd_data_o <= {2'h0, snap_ns};
      end
      else if (addr_i == `PTC_ADDR_NOW_FRAC)
      begin
        rd_data_o <= snap_frac;
      end
      else if (addr_i == `PTC_ADDR_STATUS)
      begin
        rd_data_o <= {30'h0, temp_active_o, run};
      end
      else
      begin
        rd_data_o <= 32'h0;
      end
    end
  end

  // Output clock sees the rate, never the steps or loads
  ptc_clkout u_clkout (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .en_i       (out_en),
    .tick_i     (tick),
    .inc_i      (inc),
    .div_i      (out_div),
    .clk_out_o  (clk_out_o)
  );

endmodule // ptc_time_clock

`default_nettype wire

// File: ptc_consts.vh
// Constants for the time-of-day clock block: register offsets, field
// positions, reset values and timing figures.
// Assumes it is included by bare name from files in the same folder.
//
// How it works
// - Time is kept as 32-bit seconds, 30-bit nanoseconds and a 32-bit fraction in 2^-32 ns.
// - A load command replaces the whole time value with the staged seconds and nanoseconds.
// - A step command adds a signed nanosecond offset, moving time forward or backward.
// - A programmed rate value changes the time added per reference tick in 2^-32 ns units.
// - A rate written with the temporary flag and a nonzero tick count holds only for that count.
// - Time is unsigned; a step below zero seconds wraps and software handles sign.
// - Only 32 bits of seconds are held, and the count simply rolls over.
// - The output clock is 250 MHz divided by a divisor from 2 to 255, others ignored; where the half period is below the tick advance it toggles once per tick.
// - The output clock advances with the same corrected increment as the time clock.
// - Steps and loads move the time only; the output clock phase is left alone.
// - The nanosecond count moves 8 ns per internal or external tick and 32 ns per divided tick, before rate correction.
// - Time advances on an internal tick, a divided-down tick or an external reference.
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// Register offsets
`define PTC_ADDR_CTRL     4'h0
`define PTC_ADDR_SET_NS   4'h1
`define PTC_ADDR_SET_SEC  4'h2
`define PTC_ADDR_STEP     4'h3
`define PTC_ADDR_RATE     4'h4
`define PTC_ADDR_RATE_DUR 4'h5
`define PTC_ADDR_COC      4'h6
`define PTC_ADDR_NOW_SEC  4'h7
`define PTC_ADDR_NOW_NS   4'h8
`define PTC_ADDR_NOW_FRAC 4'h9
`define PTC_ADDR_STATUS   4'ha

// Control register fields
`define PTC_CTRL_RUN      0
`define PTC_CTRL_LOAD     1
`define PTC_CTRL_STEP     2
`define PTC_CTRL_REF_LO   4
`define PTC_CTRL_REF_HI   5
`define PTC_CTRL_OUT_EN   6
`define PTC_CTRL_RST      7'h41

// Reference selection codes
`define PTC_REF_INT       2'h0
`define PTC_REF_DIV       2'h1
`define PTC_REF_EXT       2'h2

// Rate register fields
`define PTC_RATE_DIR      31
`define PTC_RATE_TEMP     30
`define PTC_RATE_VAL_HI   29

// Clock output divisor
`define PTC_COC_DIV_MIN   8'h02
`define PTC_COC_DIV_MAX   8'hff
`define PTC_COC_DIV_RST   8'h0a

// Timing figures
`define PTC_REF_PERIOD_NS 4'h8
`define PTC_REF_DIV_LAST  2'h3
`define PTC_NS_PER_SEC    30'h3b9aca00
`define PTC_OUT_HALF_NS   2'h2

`endif

// File: ptc_sync2.v
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a plain level with no timing relation to core_clk_i.
`timescale 1ns/1ps
`default_nettype none

module ptc_sync2 (
  input  wire core_clk_i,
  input  wire rst_b_i,
  input  wire ce_i,
  input  wire async_i,
  output reg  sync_o
);

  reg meta;

  // First stage is read by the second stage only
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end
    else if (ce_i)
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // ptc_sync2

`default_nettype wire

// File: ptc_clkout.v
// Frequency-corrected clock output built as a phase accumulator.
// Assumes tick_i and inc_i come from the time clock on the same clock.
`timescale 1ns/1ps
`include "ptc_consts.vh"
`default_nettype none

module ptc_clkout (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire        ce_i,
  input  wire        en_i,
  input  wire        tick_i,
  input  wire [37:0] inc_i,
  input  wire [7:0]  div_i,
  output reg         clk_out_o
);

  reg  [41:0] phase;
  wire [9:0]  half_ns;
  wire [41:0] half;
  wire [41:0] sum;
  wire [41:0] rem;

  // Half period is div * 2 ns, the 250 MHz period being 4 ns
  assign half_ns = {2'b00, div_i} * {8'h00, `PTC_OUT_HALF_NS};
  assign half    = {half_ns, 32'h0};
  assign sum  = phase + {4'h0, inc_i};
  assign rem  = sum - half;

  // The output can only toggle once per tick, so a half period below the
  // tick advance saturates the phase instead of letting it run away
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      phase     <= 42'h0;
      clk_out_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en_i)
      begin
        phase     <= 42'h0;
        clk_out_o <= 1'b0;
      end
      else if (tick_i)
      begin
        if (sum >= half)
        begin
          clk_out_o <= ~clk_out_o;
          phase     <= (rem >= half) ? half : rem;
        end
        else
        begin
          phase <= sum;
        end
      end
    end
  end

endmodule // ptc_clkout

`default_nettype wire

// File: ptc_time_clock_properties.sv
// Checker for the time clock ports: read timing, time ranges and carries.
// Assumes one core clock and a synchronous active-low reset on the block.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"

module ptc_time_clock_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        ext_ref_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [31:0] time_sec_o,
  input wire logic [29:0] time_ns_o,
  input wire logic        temp_active_o,
  input wire logic        clk_out_o
);
  // All checks share the core clock and pause while reset is low
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Read answers stand one cycle only, so software never sees stale data
  a_rd_idle_zero: assert property ((ce_i && !rd_i) |=> rd_data_o == 32'h0)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property ((ce_i && rd_i && addr_i > 4'ha) |=> rd_data_o == 32'h0)
    else $error("unmapped read not zero");
  a_now_sec_read: assert property ((ce_i && rd_i && addr_i == `PTC_ADDR_NOW_SEC)
    |=> rd_data_o == $past(time_sec_o))
    else $error("seconds read differs from live seconds");
  a_status_temp: assert property ((ce_i && rd_i && addr_i == `PTC_ADDR_STATUS)
    |=> rd_data_o[1] == $past(temp_active_o))
    else $error("status temporary flag wrong");
  // Time fields
  a_ns_in_range: assert property (time_ns_o < `PTC_NS_PER_SEC)
    else $error("nanoseconds out of range");
  a_hold_no_ce: assert property (!ce_i |=> $stable(time_ns_o) && $stable(time_sec_o))
    else $error("time moved without clock enable");
  // Without a write, seconds only move by a carry out of nanoseconds
  a_sec_by_carry: assert property ((!$past(wr_i) && time_sec_o != $past(time_sec_o))
    |-> time_sec_o == $past(time_sec_o) + 32'h1 && time_ns_o < $past(time_ns_o))
    else $error("seconds changed without carry");
  a_reset_clears: assert property ($rose(rst_b_i) |-> time_sec_o == 32'h0 &&
    time_ns_o == 30'h0 && !temp_active_o && !clk_out_o)
    else $error("outputs not cleared by reset");
  a_temp_after_wr: assert property ($rose(temp_active_o) |-> $past(wr_i))
    else $error("temporary rate started without write");

  // Main scenarios
  c_temp_start: cover property ($rose(temp_active_o));
  c_temp_end: cover property ($fell(temp_active_o));
  c_sec_carry: cover property (!$past(wr_i) && time_sec_o == $past(time_sec_o) + 32'h1);
  c_clk_rise: cover property ($rose(clk_out_o));
endmodule // ptc_time_clock_chk

bind ptc_time_clock ptc_time_clock_chk u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .ext_ref_i(ext_ref_i),
  .rd_data_o(rd_data_o), .time_sec_o(time_sec_o), .time_ns_o(time_ns_o),
  .temp_active_o(temp_active_o), .clk_out_o(clk_out_o)
);
`default_nettype wire

// File: ptp_time_clock_with_output_tb_top.sv
// Bench for the time clock: rate and reference table, then load, step,
// temporary rate, output clock and mid-run reset cases.
// Assumes the time clock and its checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.vh"

module ptp_time_clock_with_output_tb_top;
  typedef struct {logic [7:0] ctrl; logic [31:0] rate; logic [29:0] delta;} ptc_row_t;
  logic        core_clk_i;
  logic        rst_b_i;
  logic        ce_i;
  logic [3:0]  addr_i;
  logic [31:0] wr_data_i;
  logic        wr_i;
  logic        rd_i;
  logic        ext_ref_i = 1'b0;
  logic [2:0]  erc = 3'h0;
  wire  [31:0] rd_data_o;
  wire  [31:0] time_sec_o;
  wire  [29:0] time_ns_o;
  wire         temp_active_o;
  wire         clk_out_o;
  int          n_errors;
  int          num_checks;
  int          cnt;
  int          i;
  logic [31:0] rdv;
  logic [29:0] ns0;
  // Reference mode, rate, nanoseconds gained over 16 cycles
  ptc_row_t    rows [0:4] = '{'{8'h01, 32'h0, 30'h80}, '{8'h01, 32'h20000000, 30'h82},
                              '{8'h01, 32'ha0000000, 30'h7e}, '{8'h11, 32'h0, 30'h80},
                              '{8'h21, 32'h0, 30'h10}};

  ptc_time_clock uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .ext_ref_i(ext_ref_i),
    .rd_data_o(rd_data_o), .time_sec_o(time_sec_o), .time_ns_o(time_ns_o),
    .temp_active_o(temp_active_o), .clk_out_o(clk_out_o)
  );

  // 100 MHz core clock
  initial core_clk_i = 1'b0;
  always #5 core_clk_i = ~core_clk_i;

  // External reference with an 8-cycle period, so 16 cycles hold two edges
  always @(posedge core_clk_i)
  begin
    erc <= erc + 3'h1;
    ext_ref_i <= erc[2];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe only
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    rdv = rd_data_o;
  endtask

  task automatic load(input logic [31:0] s, input logic [31:0] n, input logic [31:0] c);
    wr(`PTC_ADDR_SET_NS, n);
    wr(`PTC_ADDR_SET_SEC, s);
    wr(`PTC_ADDR_CTRL, c);
  endtask

  // Step with the clock stopped, so no tick lands on top of it
  task automatic stp(input logic [31:0] o, input logic [31:0] s, input logic [31:0] n);
    wr(`PTC_ADDR_STEP, o);
    wr(`PTC_ADDR_CTRL, 32'h04);
    #1;
    chk(time_sec_o, s);
    chk({2'h0, time_ns_o}, n);
  endtask

  // Counts output clock edges; each is half a period of the divided clock
  task automatic tog(input int n, input logic [31:0] e);
    logic p;
    int   c;
    c = 0;
    cyc(1);
    p = clk_out_o;
    repeat (n)
    begin
      cyc(1);
      if (clk_out_o !== p)
        c++;
      p = clk_out_o;
    end
    chk(c, e);
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    test_done;
  end

  initial
  begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 4'h0;
    wr_data_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      wr(`PTC_ADDR_CTRL, 32'h0);
      wr(`PTC_ADDR_RATE, rows[i].rate);
      rd(`PTC_ADDR_RATE);
      chk(rdv, rows[i].rate);
      load(32'h0, 32'h0, {24'h0, rows[i].ctrl} | 32'h2);
      cyc(4);
      ns0 = time_ns_o;
      cyc(16);
      chk({2'h0, time_ns_o - ns0}, {2'h0, rows[i].delta});
    end
    // Load just below a second boundary, then carry
    load(32'h12345678, 32'h3b9ac9f0, 32'h43);
    #1;
    chk(time_sec_o, 32'h12345678);
    chk({2'h0, time_ns_o}, 32'h3b9ac9f0);
    cyc(2);
    chk(time_sec_o, 32'h12345679);
    chk({2'h0, time_ns_o}, 32'h0);
    // Signed steps across seconds and below zero time
    load(32'h5, 32'h64, 32'h02);
    stp(32'hffffff38, 32'h4, 32'h3b9ac99c);
    stp(32'h12c, 32'h5, 32'hc8);
    load(32'h0, 32'h0, 32'h02);
    stp(32'hfffffff8, 32'hffffffff, 32'h3b9ac9f8);
    stp(32'h8, 32'h0, 32'h0);
    // Temporary faster rate for ten ticks, then back to the permanent rate
    load(32'h0, 32'h0, 32'h43);
    wr(`PTC_ADDR_RATE_DUR, 32'ha);
    wr(`PTC_ADDR_RATE, 32'h60000000);
    rd(`PTC_ADDR_STATUS);
    chk(rdv, 32'h3);
    // Flag already stood after the write edge and through the status read
    cnt = 3;
    repeat (40)
    begin
      cyc(1);
      if (temp_active_o === 1'b1)
        cnt++;
    end
    chk(cnt, 32'ha);
    ns0 = time_ns_o;
    cyc(16);
    chk({2'h0, time_ns_o - ns0}, 32'h80);
    // Seconds read freezes ns and fraction; live ns has moved one tick on
    rd(`PTC_ADDR_NOW_SEC);
    chk(rdv, 32'h0);
    ns0 = time_ns_o - 30'h8;
    rd(`PTC_ADDR_NOW_NS);
    chk(rdv, {2'h0, ns0});
    rd(`PTC_ADDR_NOW_FRAC);
    chk(rdv, 32'h40000000);
    // Divisor limits and rate tracking on the output clock
    wr(`PTC_ADDR_COC, 32'h19);
    wr(`PTC_ADDR_COC, 32'h1);
    wr(`PTC_ADDR_COC, 32'h100);
    rd(`PTC_ADDR_COC);
    chk(rdv, 32'h19);
    tog(400, 32'h40);
    wr(`PTC_ADDR_RATE, 32'h20000000);
    tog(400, 32'h41);
    load(32'h7, 32'h0, 32'h43);
    tog(400, 32'h41);
    // Clock enable low freezes everything
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    #1;
    ns0 = time_ns_o;
    repeat (5) @(posedge core_clk_i);
    ce_i <= 1'b1;
    #1;
    chk({2'h0, time_ns_o}, {2'h0, ns0});
    // Mid-run reset, then reset values
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(`PTC_ADDR_CTRL);
    chk(rdv, 32'h41);
    rd(`PTC_ADDR_RATE);
    chk(rdv, 32'h0);
    rd(`PTC_ADDR_COC);
    chk(rdv, 32'ha);
    rd(`PTC_ADDR_STATUS);
    chk(rdv, 32'h1);
    rd(4'hb);
    chk(rdv, 32'h0);
    rd(`PTC_ADDR_NOW_SEC);
    chk(rdv, 32'h0);
    test_done;
  end
endmodule // ptp_time_clock_with_output_tb_top
`default_nettype wire
